// >>> pin_func_pkg.sv
// constants for the serial controller pin function block
package pin_func_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_IO_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ARM_CTRL  = 8'h04;
    localparam logic [7:0] OFF_LATCH_STS = 8'h08;
    localparam logic [7:0] OFF_PORT_CTRL = 8'h0c;
    localparam logic [7:0] OFF_PORT_STS  = 8'h10;
    localparam logic [7:0] OFF_TX_CTRL   = 8'h14;
    localparam logic [15:0] RST_REG      = 16'h0000;
    localparam logic [2:0]  RST_TX_CTRL  = 3'h0;
    // pin_io_control field positions
    localparam int CTS_MODE_LSB = 14;
    localparam int TXR_MODE_LSB = 10;
    localparam int RXR_MODE_LSB = 8;
    localparam int TXC_MODE_LSB = 3;
    localparam int RXC_MODE_LSB = 0;
    // edge arm and latch status bit positions
    localparam int RXC_FALL = 15;
    localparam int RXC_RISE = 14;
    localparam int TXC_ARM  = 13;
    localparam int RXR_FALL = 11;
    localparam int RXR_RISE = 10;
    localparam int TXR_FALL = 9;
    localparam int TXR_RISE = 8;
    localparam int CTS_FALL = 5;
    localparam int CTS_RISE = 4;
    localparam int RXC_LU   = 15;
    localparam int TXC_LU   = 13;
    localparam int RXR_LU   = 11;
    localparam int TXR_LU   = 9;
    localparam int CTS_LU   = 5;
    // tx control fields
    localparam int TX_ASYNC_BIT = 2;
    localparam logic [1:0] TX_EN_OFF = 2'h0;
    localparam logic [1:0] TX_EN_CTS = 2'h3;
    // two-bit pin modes
    localparam logic [1:0] M2_IN   = 2'h0;
    localparam logic [1:0] M2_FUNC = 2'h1;
    localparam logic [1:0] M2_LOW  = 2'h2;
    localparam logic [1:0] M2_HIGH = 2'h3;
    // clock pin modes
    localparam logic [2:0] CK_IN   = 3'h0;
    localparam logic [2:0] CK_BIT  = 3'h1;
    localparam logic [2:0] CK_CHAR = 3'h2;
    localparam logic [2:0] CK_AUX  = 3'h3;
    localparam logic [2:0] CK_BAUD_GENERATOR_ZERO = 3'h4;
    localparam logic [2:0] CK_BAUD_GENERATOR_ONE = 3'h5;
    localparam logic [2:0] CK_CTR  = 3'h6;
    localparam logic [2:0] CK_PLL  = 3'h7;
    // port pins with dedicated outputs
    localparam int PORT_TXCMP = 7;
    localparam int PORT_RSYNC = 5;
    // rising bit clock edges after the one that first sees cts low
    localparam logic [2:0] CTS_START_RISES = 3'h4;
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} tx_state_e;
endpackage

// >>> pin_edge_cell.sv
// synchroniser, edge detector and latched/unlatched status for one pin
`timescale 1ns/100ps
module pin_edge_cell
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    input  wire logic arm_rise,
    input  wire logic arm_fall,
    input  wire logic clear,
    output logic      pin_low,
    output logic      latched,
    output logic      data
);
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       prev;
        logic       pend;
        logic       lu;
        logic       data;
        logic [2:0] warm;
    } cell_s;

    cell_s q;
    cell_s d;
    logic  edge_seen;

    always_comb
    begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.prev = q.s2;
        d.warm = {q.warm[1:0], 1'b1};
        // second stage only, and not before the stages fill, so reset is no edge
        edge_seen = q.warm[2] & ((q.s2 & ~q.prev & arm_rise) | (~q.s2 & q.prev & arm_fall));
        // an edge during the clearing write is kept and re-latches next cycle
        d.pend = edge_seen | (q.pend & (q.lu | clear));
        if (clear)
        begin
            d.lu = 1'b0;
        end
        else if (!q.lu && q.pend)
        begin
            d.lu = 1'b1;
        end
        // data tracks the pin while unlatched, frozen while latched
        if ((!q.lu || clear) && q.warm[1])
        begin
            d.data = ~q.s2;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign pin_low = ~q.s2;
    assign latched = q.lu;
    assign data    = q.data;
endmodule

// >>> pin_functions.sv
// pin function mux, edge latches, cts transmit gate and ahb-lite registers
`timescale 1ns/100ps
// Summary of operation
// - cts mode: 0x input, 10 drive low, 11 drive high
// - tx enable 11 lets a character start only while cts is low
// - first bit starts at falling bit clock edge 4.5 periods after cts seen low
// - cts high mid-character: async finishes character, sync stops at once
// - cts pin undriven from reset until mode 10 or 11
// - arm bits 5 and 4 detect cts falling and rising edges
// - cts latch bit sets on armed edge; data bit tracks pin only while unlatched
// - rx clock pin mode selects input or one of seven internal sources
// - tx clock pin mode selects input or one of seven internal sources
// - rx character clock high one rx period per character into receive fifo
// - tx character clock high one tx period per character into shift register
// - rx sync output low one rx period per sync or flag found
// - tx complete low from first bit of a run to end of its last bit
// - baud generator and counter outputs drive the clock pins as square waves
// - arm bits 15,14 for rx clock pin edges, bit 13 for tx clock edges
// - clock pin latch bits 15,13 with data bits 14,12 tracking while unlatched
// - request pin modes: 00 input, 01 request out, 10 low, 11 high
// - internal dma requests work whatever the request pin modes are
// - request pin latch bits with data bits tracking while unlatched
// - all eight port pins are latched but never raise an interrupt
// - port mode: 00 input, 01 dedicated, 10 drive low
// - writing 1 clears a port latch and resamples; an edge relatches with direction
// - writing 0 to a latch or any data bit does nothing; missed edges relatch
module pin_functions
#(
    parameter int PORTS = 8
)
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    input  wire logic             cts_in,
    output logic                  cts_out,
    output logic                  cts_oe,
    input  wire logic             rx_clock_pin_in,
    output logic                  rx_clock_pin_out,
    output logic                  rx_clock_pin_oe,
    input  wire logic             tx_clock_pin_in,
    output logic                  tx_clock_pin_out,
    output logic                  tx_clock_pin_oe,
    input  wire logic             rx_request_pin_in,
    output logic                  rx_request_pin_out,
    output logic                  rx_request_pin_oe,
    input  wire logic             tx_request_pin_in,
    output logic                  tx_request_pin_out,
    output logic                  tx_request_pin_oe,
    input  wire logic [PORTS-1:0] port_pin_in,
    output logic [PORTS-1:0]      port_pin_out,
    output logic [PORTS-1:0]      port_pin_oe,
    input  wire logic             receive_bit_clock,
    input  wire logic             transmit_bit_clock,
    input  wire logic             rx_bit_rise,
    input  wire logic             tx_bit_rise,
    input  wire logic             tx_bit_fall,
    input  wire logic             baud_generator_zero,
    input  wire logic             baud_generator_one,
    input  wire logic             counter_zero,
    input  wire logic             counter_one,
    input  wire logic             pll_rx_clock,
    input  wire logic             pll_tx_clock,
    input  wire logic             rx_fifo_load,
    input  wire logic             tx_fifo_load,
    input  wire logic             rx_sync_found,
    input  wire logic             rx_dma_request,
    input  wire logic             tx_dma_request,
    input  wire logic             tx_char_valid,
    input  wire logic             tx_char_end,
    output logic                  tx_char_start,
    output logic                  tx_abort
);
    localparam int CELLS = 5 + PORTS;

    typedef struct packed {
        logic [15:0]            io_ctrl;
        logic [15:0]            arm_ctrl;
        logic [15:0]            port_ctrl;
        logic [2:0]             tx_ctrl;
        logic                   ap_valid;
        logic                   ap_write;
        logic [7:0]             ap_addr;
        logic [31:0]            rdata;
        pin_func_pkg::tx_state_e tx_state;
        logic [2:0]             rise_cnt;
        logic                   tx_start;
        logic                   tx_abort;
        logic                   rx_char_clk;
        logic                   tx_char_clk;
        logic                   rx_sync_n;
    } state_s;

    state_s q;
    state_s d;

    logic [CELLS-1:0] cell_pin;
    logic [CELLS-1:0] cell_rise;
    logic [CELLS-1:0] cell_fall;
    logic [CELLS-1:0] cell_clear;
    logic [CELLS-1:0] cell_low;
    logic [CELLS-1:0] cell_lu;
    logic [CELLS-1:0] cell_data;
    logic [15:0]      latch_sts;
    logic [15:0]      port_sts;
    logic             wr_latch;
    logic             wr_port;
    logic             cts_ok;
    logic             tx_enabled;

    // mode field of port pin n
    function automatic logic [1:0] port_mode(input logic [15:0] port_pin_control, input int n);
        port_mode = port_pin_control[2*n +: 2];
    endfunction

    // drive for a two-bit low/high output mode; bit1 set means driven
    function automatic logic mode2_level(input logic [1:0] m);
        mode2_level = (m == pin_func_pkg::M2_HIGH);
    endfunction

    // cell order: 0 cts, 1 rx clock, 2 tx clock, 3 rx request, 4 tx request, 5.. ports
    assign cell_pin[4:0] = {tx_request_pin_in, rx_request_pin_in, tx_clock_pin_in,
                            rx_clock_pin_in, cts_in};
    assign cell_pin[CELLS-1:5] = port_pin_in;
    assign cell_fall[4:0] = {q.arm_ctrl[pin_func_pkg::TXR_FALL],
                             q.arm_ctrl[pin_func_pkg::RXR_FALL],
                             q.arm_ctrl[pin_func_pkg::TXC_ARM],
                             q.arm_ctrl[pin_func_pkg::RXC_FALL],
                             q.arm_ctrl[pin_func_pkg::CTS_FALL]};
    assign cell_rise[4:0] = {q.arm_ctrl[pin_func_pkg::TXR_RISE],
                             q.arm_ctrl[pin_func_pkg::RXR_RISE],
                             q.arm_ctrl[pin_func_pkg::TXC_ARM],
                             q.arm_ctrl[pin_func_pkg::RXC_RISE],
                             q.arm_ctrl[pin_func_pkg::CTS_RISE]};
    // ports always watch both edges whatever their direction
    assign cell_fall[CELLS-1:5] = '1;
    assign cell_rise[CELLS-1:5] = '1;

    // data phase of a write; only ones in latch positions clear, data bits ignored
    assign wr_latch = q.ap_valid & q.ap_write & (q.ap_addr == pin_func_pkg::OFF_LATCH_STS);
    assign wr_port  = q.ap_valid & q.ap_write & (q.ap_addr == pin_func_pkg::OFF_PORT_STS);
    assign cell_clear[0] = wr_latch & hwdata[pin_func_pkg::CTS_LU];
    assign cell_clear[1] = wr_latch & hwdata[pin_func_pkg::RXC_LU];
    assign cell_clear[2] = wr_latch & hwdata[pin_func_pkg::TXC_LU];
    assign cell_clear[3] = wr_latch & hwdata[pin_func_pkg::RXR_LU];
    assign cell_clear[4] = wr_latch & hwdata[pin_func_pkg::TXR_LU];

    genvar g;
    generate
        for (g = 0; g < PORTS; g++)
        begin : g_port
            assign cell_clear[5+g] = wr_port & hwdata[2*g+1];
            assign port_sts[2*g+1] = cell_lu[5+g];
            assign port_sts[2*g]   = cell_data[5+g];
        end
        for (g = 0; g < CELLS; g++)
        begin : g_cell
            pin_edge_cell u_cell (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .pin      (cell_pin[g]),
                .arm_rise (cell_rise[g]),
                .arm_fall (cell_fall[g]),
                .clear    (cell_clear[g]),
                .pin_low  (cell_low[g]),
                .latched  (cell_lu[g]),
                .data     (cell_data[g])
            );
        end
    endgenerate

    always_comb
    begin
        latch_sts = '0;
        latch_sts[pin_func_pkg::CTS_LU]     = cell_lu[0];
        latch_sts[pin_func_pkg::CTS_LU-1]   = cell_data[0];
        latch_sts[pin_func_pkg::RXC_LU]     = cell_lu[1];
        latch_sts[pin_func_pkg::RXC_LU-1]   = cell_data[1];
        latch_sts[pin_func_pkg::TXC_LU]     = cell_lu[2];
        latch_sts[pin_func_pkg::TXC_LU-1]   = cell_data[2];
        latch_sts[pin_func_pkg::RXR_LU]     = cell_lu[3];
        latch_sts[pin_func_pkg::RXR_LU-1]   = cell_data[3];
        latch_sts[pin_func_pkg::TXR_LU]     = cell_lu[4];
        latch_sts[pin_func_pkg::TXR_LU-1]   = cell_data[4];
    end

    assign tx_enabled = (q.tx_ctrl[1:0] != pin_func_pkg::TX_EN_OFF);
    // the gate only looks at cts in mode 11
    assign cts_ok = (q.tx_ctrl[1:0] != pin_func_pkg::TX_EN_CTS) | cell_low[0];

    always_comb
    begin
        d = q;
        d.tx_start = 1'b0;
        d.tx_abort = 1'b0;
        // ahb address phase; zero wait states so hready is always ours
        d.ap_valid = hsel & hready & htrans[1];
        d.ap_write = hwrite;
        d.ap_addr  = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            case (haddr[7:0])
                pin_func_pkg::OFF_IO_CTRL:   d.rdata = {16'h0000, q.io_ctrl};
                pin_func_pkg::OFF_ARM_CTRL:  d.rdata = {16'h0000, q.arm_ctrl};
                pin_func_pkg::OFF_LATCH_STS: d.rdata = {16'h0000, latch_sts};
                pin_func_pkg::OFF_PORT_CTRL: d.rdata = {16'h0000, q.port_ctrl};
                pin_func_pkg::OFF_PORT_STS:  d.rdata = {16'h0000, port_sts};
                pin_func_pkg::OFF_TX_CTRL:   d.rdata = {29'h00000000, q.tx_ctrl};
                default:                     d.rdata = 32'h00000000;
            endcase
        end
        if (q.ap_valid && q.ap_write)
        begin
            case (q.ap_addr)
                pin_func_pkg::OFF_IO_CTRL:   d.io_ctrl = hwdata[15:0];
                pin_func_pkg::OFF_ARM_CTRL:  d.arm_ctrl = hwdata[15:0];
                pin_func_pkg::OFF_PORT_CTRL: d.port_ctrl = hwdata[15:0];
                pin_func_pkg::OFF_TX_CTRL:   d.tx_ctrl = hwdata[2:0];
                default:                     d.tx_ctrl = q.tx_ctrl;
            endcase
        end

        // character clocks and sync pulse last one bit clock period
        if (rx_fifo_load)
        begin
            d.rx_char_clk = 1'b1;
        end
        else if (rx_bit_rise)
        begin
            d.rx_char_clk = 1'b0;
        end
        if (rx_sync_found)
        begin
            d.rx_sync_n = 1'b0;
        end
        else if (rx_bit_rise)
        begin
            d.rx_sync_n = 1'b1;
        end
        if (tx_fifo_load)
        begin
            d.tx_char_clk = 1'b1;
        end
        else if (tx_bit_rise)
        begin
            d.tx_char_clk = 1'b0;
        end

        case (q.tx_state)
            pin_func_pkg::TX_IDLE:
            begin
                if (tx_enabled && tx_char_valid && tx_bit_rise && cts_ok)
                begin
                    d.tx_state = pin_func_pkg::TX_WAIT;
                    d.rise_cnt = 3'h0;
                end
            end
            pin_func_pkg::TX_WAIT:
            begin
                if (!cts_ok || !tx_enabled)
                begin
                    d.tx_state = pin_func_pkg::TX_IDLE;
                end
                else if (tx_bit_rise && q.rise_cnt != pin_func_pkg::CTS_START_RISES)
                begin
                    d.rise_cnt = q.rise_cnt + 3'h1;
                end
                else if (tx_bit_fall && q.rise_cnt == pin_func_pkg::CTS_START_RISES)
                begin
                    // falling edge 4.5 periods after the sampling rise
                    d.tx_start = 1'b1;
                    d.tx_state = pin_func_pkg::TX_SEND;
                end
            end
            pin_func_pkg::TX_SEND:
            begin
                if (!cts_ok && !q.tx_ctrl[pin_func_pkg::TX_ASYNC_BIT])
                begin
                    // synchronous modes drop the line at once
                    d.tx_abort = 1'b1;
                    d.tx_state = pin_func_pkg::TX_IDLE;
                end
                else if (tx_char_end)
                begin
                    // async finishes the character, then a run continues only if allowed
                    if (tx_enabled && tx_char_valid && cts_ok)
                    begin
                        d.tx_start = 1'b1;
                    end
                    else
                    begin
                        d.tx_state = pin_func_pkg::TX_IDLE;
                    end
                end
            end
            default:
            begin
                d.tx_state = pin_func_pkg::TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
            q.io_ctrl   <= pin_func_pkg::RST_REG;
            q.arm_ctrl  <= pin_func_pkg::RST_REG;
            q.port_ctrl <= pin_func_pkg::RST_REG;
            q.tx_ctrl   <= pin_func_pkg::RST_TX_CTRL;
            q.tx_state  <= pin_func_pkg::TX_IDLE;
            q.rx_sync_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = q.rdata;
    assign tx_char_start = q.tx_start;
    assign tx_abort      = q.tx_abort;

    // cts: driven only for modes 10 and 11, so reset leaves it floating
    assign cts_oe  = q.io_ctrl[pin_func_pkg::CTS_MODE_LSB+1];
    assign cts_out = q.io_ctrl[pin_func_pkg::CTS_MODE_LSB];

    // request pins; the internal dma path never looks at these modes
    always_comb
    begin
        logic [1:0] rm;
        logic [1:0] tm;
        rm = q.io_ctrl[pin_func_pkg::RXR_MODE_LSB +: 2];
        tm = q.io_ctrl[pin_func_pkg::TXR_MODE_LSB +: 2];
        rx_request_pin_oe  = (rm != pin_func_pkg::M2_IN);
        tx_request_pin_oe  = (tm != pin_func_pkg::M2_IN);
        rx_request_pin_out = (rm == pin_func_pkg::M2_FUNC) ? ~rx_dma_request : mode2_level(rm);
        tx_request_pin_out = (tm == pin_func_pkg::M2_FUNC) ? ~tx_dma_request : mode2_level(tm);
    end

    // clock pins carry internal square waves or status straight through
    always_comb
    begin
        logic [2:0] rc;
        logic [2:0] tc;
        rc = q.io_ctrl[pin_func_pkg::RXC_MODE_LSB +: 3];
        tc = q.io_ctrl[pin_func_pkg::TXC_MODE_LSB +: 3];
        rx_clock_pin_oe = (rc != pin_func_pkg::CK_IN);
        tx_clock_pin_oe = (tc != pin_func_pkg::CK_IN);
        case (rc)
            pin_func_pkg::CK_BIT:  rx_clock_pin_out = receive_bit_clock;
            pin_func_pkg::CK_CHAR: rx_clock_pin_out = q.rx_char_clk;
            pin_func_pkg::CK_AUX:  rx_clock_pin_out = q.rx_sync_n;
            pin_func_pkg::CK_BAUD_GENERATOR_ZERO: rx_clock_pin_out = baud_generator_zero;
            pin_func_pkg::CK_BAUD_GENERATOR_ONE: rx_clock_pin_out = baud_generator_one;
            pin_func_pkg::CK_CTR:  rx_clock_pin_out = counter_zero;
            pin_func_pkg::CK_PLL:  rx_clock_pin_out = pll_rx_clock;
            default:               rx_clock_pin_out = 1'b0;
        endcase
        case (tc)
            pin_func_pkg::CK_BIT:  tx_clock_pin_out = transmit_bit_clock;
            pin_func_pkg::CK_CHAR: tx_clock_pin_out = q.tx_char_clk;
            // tx complete low for the whole run
            pin_func_pkg::CK_AUX:  tx_clock_pin_out = (q.tx_state != pin_func_pkg::TX_SEND);
            pin_func_pkg::CK_BAUD_GENERATOR_ZERO: tx_clock_pin_out = baud_generator_zero;
            pin_func_pkg::CK_BAUD_GENERATOR_ONE: tx_clock_pin_out = baud_generator_one;
            pin_func_pkg::CK_CTR:  tx_clock_pin_out = counter_one;
            pin_func_pkg::CK_PLL:  tx_clock_pin_out = pll_tx_clock;
            default:               tx_clock_pin_out = 1'b0;
        endcase
    end

    // port pins; dedicated inputs are left undriven
    generate
        for (g = 0; g < PORTS; g++)
        begin : g_port_drv
            logic [1:0] pm;
            logic       ded_out;
            assign pm = port_mode(q.port_ctrl, g);
            if (g == pin_func_pkg::PORT_TXCMP)
            begin : g_txc
                assign ded_out = 1'b1;
                assign port_pin_out[g] = (pm == pin_func_pkg::M2_FUNC) ?
                                         (q.tx_state != pin_func_pkg::TX_SEND) :
                                         mode2_level(pm);
            end
            else if (g == pin_func_pkg::PORT_RSYNC)
            begin : g_rs
                assign ded_out = 1'b1;
                assign port_pin_out[g] = (pm == pin_func_pkg::M2_FUNC) ?
                                         q.rx_sync_n : mode2_level(pm);
            end
            else
            begin : g_gp
                assign ded_out = 1'b0;
                assign port_pin_out[g] = mode2_level(pm);
            end
            assign port_pin_oe[g] = pm[1] | ((pm == pin_func_pkg::M2_FUNC) & ded_out);
        end
    endgenerate
endmodule

// >>> pin_functions_checker.sv
// port-level assertions for the pin function block
`timescale 1ns/100ps
module pin_functions_checker
(
    input wire logic        hclk, hresetn, hsel, hready, hwrite, cts_oe, cts_out,
    input wire logic [31:0] haddr, hwdata,
    input wire logic [1:0]  htrans,
    input wire logic        rx_clock_pin_out, tx_clock_pin_out, tx_clock_pin_oe,
    input wire logic        rx_request_pin_out, rx_request_pin_oe, rx_dma_request,
    input wire logic        receive_bit_clock, baud_generator_one
);
    logic        wr_q;
    logic [15:0] ioc_q;
    // shadow of the io control word, taken at the end of each write data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q  <= 1'b0;
            ioc_q <= 16'h0000;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
            if (wr_q)
                ioc_q <= hwdata[15:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_cts_enable: assert property (cts_oe == ioc_q[15])
        else $error("cts enable wrong");
    a_cts_level: assert property (cts_oe |-> cts_out == ioc_q[14])
        else $error("cts level wrong");
    a_req_enable: assert property (rx_request_pin_oe == (ioc_q[9:8] != 2'h0))
        else $error("request enable wrong");
    a_req_fixed: assert property (ioc_q[9] |-> rx_request_pin_out == ioc_q[8])
        else $error("request level wrong");
    a_req_dma: assert property (ioc_q[9:8] == 2'h1 |-> rx_request_pin_out != rx_dma_request)
        else $error("request output wrong");
    a_rxc_bit: assert property (ioc_q[2:0] == 3'h1 |-> rx_clock_pin_out == receive_bit_clock)
        else $error("rx clock source wrong");
    a_txc_enable: assert property (tx_clock_pin_oe == (ioc_q[5:3] != 3'h0))
        else $error("tx clock enable wrong");
    a_txc_baud: assert property (ioc_q[5:3] == 3'h5 |-> tx_clock_pin_out == baud_generator_one)
        else $error("tx clock source wrong");
endmodule
bind pin_functions pin_functions_checker pin_functions_checker_inst (.*);

// >>> pin_far_side.sv
// board side of the pins: pulled-up lines that the bench may pull low
`timescale 1ns/100ps
module pin_far_side
(
    input  wire logic [12:0] oe,
    input  wire logic [12:0] out,
    input  wire logic [12:0] lvl,
    output logic      [12:0] pin
);
    // a released line falls back to the level the bench sets, never the last driven one
    assign pin = (oe & out) | (~oe & lvl);
endmodule

// >>> testbench.sv
// self-checking bench for the pin function block
`timescale 1ns/100ps
module testbench;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cts_in, cts_out, cts_oe;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic rx_clock_pin_in, rx_clock_pin_out, rx_clock_pin_oe, tx_clock_pin_in, tx_clock_pin_out;
    logic tx_clock_pin_oe, rx_request_pin_in, rx_request_pin_out, rx_request_pin_oe, tx_abort;
    logic tx_request_pin_in, tx_request_pin_out, tx_request_pin_oe, tx_char_start, tx_char_valid;
    logic [7:0] port_pin_in, port_pin_out, port_pin_oe, cnt;
    logic receive_bit_clock, transmit_bit_clock, rx_bit_rise, tx_bit_rise, tx_bit_fall;
    logic baud_generator_zero, baud_generator_one, counter_zero, counter_one, pll_rx_clock;
    logic pll_tx_clock, rx_fifo_load, tx_fifo_load, rx_sync_found, rx_dma_request;
    logic tx_dma_request, tx_char_end;
    logic [12:0] lvl;
    int n_errors, checks;
    // free-running sources so every mux leg except tx complete sees activity
    assign hready = hreadyout;
    assign {receive_bit_clock, transmit_bit_clock, baud_generator_zero, baud_generator_one} = cnt[3:0];
    assign {counter_zero, counter_one, pll_rx_clock, pll_tx_clock} = cnt[5:2];
    assign {rx_bit_rise, tx_bit_rise, tx_bit_fall} = {cnt[3:0] == 4'h7, cnt[2:0] == 3'h3, cnt[2:0] == 3'h7};
    assign {rx_fifo_load, tx_fifo_load, rx_sync_found, tx_char_end} = {4{cnt == 8'h30}};
    assign {rx_dma_request, tx_dma_request} = cnt[6:5];
    pin_functions pin_functions_inst (.*);
    pin_far_side pin_far_side_inst
    (
        .oe  ({cts_oe, rx_clock_pin_oe, tx_clock_pin_oe, rx_request_pin_oe, tx_request_pin_oe, port_pin_oe}),
        .out ({cts_out, rx_clock_pin_out, tx_clock_pin_out, rx_request_pin_out, tx_request_pin_out, port_pin_out}),
        .lvl (lvl),
        .pin ({cts_in, rx_clock_pin_in, tx_clock_pin_in, rx_request_pin_in, tx_request_pin_in, port_pin_in})
    );
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) cnt <= cnt + 8'h01;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single transfer; the address phase is held until hready, data taken at the next
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'h2, w};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic t_modes;
        logic [15:0] v;
        for (int m = 0; m < 4; m++)
        begin
            v = {m[1:0], 2'h0, m[1:0], m[1:0], 2'h0, 3'h5, 3'h1};
            bus(1'b1, 8'h00, {16'h0, v});
            #1;
            chk({cts_oe, cts_in}, {m[1], m[1] ? m[0] : 1'b1});
            chk(tx_request_pin_oe, m != 0);
            rd(8'h00, {16'h0, v});
        end
    endtask
    task automatic t_cts_latch;
        bus(1'b1, 8'h04, 32'h30);
        bus(1'b1, 8'h00, 32'h0);
        lvl[12] <= 1'b0;
        repeat (6) @(posedge hclk);
        rd(8'h08, 32'h30);
        lvl[12] <= 1'b1;
        repeat (6) @(posedge hclk);
        rd(8'h08, 32'h30);
        bus(1'b1, 8'h08, 32'hffcf);
        rd(8'h08, 32'h30);
        bus(1'b1, 8'h08, 32'h20);
        rd(8'h08, 32'h20);
        bus(1'b1, 8'h08, 32'h20);
        rd(8'h08, 32'h0);
    endtask
    task automatic t_port;
        bus(1'b1, 8'h0c, 32'he000);
        #1;
        chk({port_pin_oe[7:6], port_pin_out[7:6]}, 4'b1110);
        lvl[0] <= 1'b0;
        repeat (6) @(posedge hclk);
        rd(8'h10, 32'h3003);
        bus(1'b1, 8'h10, 32'h2);
        rd(8'h10, 32'h3001);
        rd(8'h40, 32'h0);
    endtask
    task conclude;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, tx_char_valid, cnt} = '0;
        {hsize, lvl, n_errors, checks} = {3'h2, 13'h1fff, 64'h0};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk(cts_oe, 1'b0);
        rd(8'h08, 32'h0);
        t_modes;
        t_cts_latch;
        t_port;
        conclude;
    end
    initial
    begin
        #50000;
        n_errors = n_errors + 1;
        conclude;
    end
endmodule
